// [core/rvm_prio_enc.sv]
`timescale 1ns/1ps

// ******************************************************************
// Lowest-index-wins priority encoder.
// ******************************************************************
module rvm_prio_enc #(
  parameter int N     = 25,
  parameter int IDX_W = 5
) (
  input  wire logic [N-1:0]     req,
  output logic                  found,
  output logic [IDX_W-1:0]      idx
);

  // Scan from the top down so that the lowest set bit is left last.
  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = IDX_W'(i);
      end
    end
  end

endmodule : rvm_prio_enc

// [core/rvm_sync2.sv]
`timescale 1ns/1ps

// ******************************************************************
// Two-flop synchroniser for a level from outside the clock domain.
// ******************************************************************
module rvm_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      sync_out
);

  // First stage; only the second stage reads it.
  logic meta_reg;

  // Both stages take the constant idle level under reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : rvm_sync2

// [core/rvm_vector_map.sv]
`timescale 1ns/1ps

// How it works
// - All reset causes fetch from word zero.
// - External pin requests go to words 1, 2.
// - Pin-change groups go to words 3 to 5.
// - Watchdog word 6; async 8-bit timer 7 to 9.
// - 16-bit timer uses words 0x00A to 0x00D.
// - Sync 8-bit timer uses words 0x00E to 0x010.
// - Serial transfer done goes to word 0x011.
// - USART events go to words 0x012 to 0x014.
// - ADC, EEPROM, comparator go to 0x015 to 0x017.
// - Two-wire interface goes to word 0x018.
// - Self-program ready is last, word 0x019.
// - One word per entry: address equals number less one.
// - No relocation of reset or vector base.
module rvm_vector_map (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        ext_reset_pin_n,
  input  wire logic                        power_on_event,
  input  wire logic                        brown_out_event,
  input  wire logic                        watchdog_reset_event,
  input  wire logic                        global_irq_enable,
  input  wire logic                        cpu_irq_accept,
  input  wire logic                        ext_pin_irq_a,
  input  wire logic                        ext_pin_irq_b,
  input  wire logic                        pin_change_group_a,
  input  wire logic                        pin_change_group_b,
  input  wire logic                        pin_change_group_c,
  input  wire logic                        watchdog_timeout_irq,
  input  wire logic                        t8b_async_match_a,
  input  wire logic                        t8b_async_match_b,
  input  wire logic                        t8b_async_wrap,
  input  wire logic                        t16_capture_irq,
  input  wire logic                        t16_match_a,
  input  wire logic                        t16_match_b,
  input  wire logic                        t16_wrap,
  input  wire logic                        t8b_sync_match_a,
  input  wire logic                        t8b_sync_match_b,
  input  wire logic                        t8b_sync_wrap,
  input  wire logic                        spi_xfer_done_irq,
  input  wire logic                        usart_rx_done_irq,
  input  wire logic                        usart_tx_buf_empty_irq,
  input  wire logic                        usart_tx_done_irq,
  input  wire logic                        adc_done_irq,
  input  wire logic                        eeprom_idle_irq,
  input  wire logic                        acomp_irq,
  input  wire logic                        two_wire_irq,
  input  wire logic                        self_program_idle_irq,
  output logic                             fetch_restart,
  output logic                             irq_pending,
  output logic [rvm_pkg::RVM_PC_W-1:0]     vector_addr,
  output logic [rvm_pkg::RVM_NUM_SRC-1:0]  served_onehot
);

  import rvm_pkg::*;

  // ****************************************************************
  // Request gathering.
  // ****************************************************************
  // Requests packed in ascending vector order; bit 0 is the highest.
  wire logic [RVM_NUM_SRC-1:0] req_vec;
  // Synchronised external reset pin, low while asserted.
  logic                        ext_reset_sync_n;
  // Any reset cause in this cycle.
  wire logic                   restart_cause;
  // Requests that may be offered now.
  wire logic [RVM_NUM_SRC-1:0] live_req;
  // Encoder results.
  logic                        win_found;
  logic [RVM_IDX_W-1:0]        win_idx;

  assign req_vec = {self_program_idle_irq, two_wire_irq, acomp_irq,
                    eeprom_idle_irq, adc_done_irq, usart_tx_done_irq,
                    usart_tx_buf_empty_irq, usart_rx_done_irq,
                    spi_xfer_done_irq, t8b_sync_wrap, t8b_sync_match_b,
                    t8b_sync_match_a, t16_wrap, t16_match_b, t16_match_a,
                    t16_capture_irq, t8b_async_wrap, t8b_async_match_b,
                    t8b_async_match_a, watchdog_timeout_irq,
                    pin_change_group_c, pin_change_group_b,
                    pin_change_group_a, ext_pin_irq_b, ext_pin_irq_a};

  // The pin comes from outside the clock domain; it idles high.
  rvm_sync2 #(
    .RESET_VAL (1'b1)
  ) u_ext_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (ext_reset_pin_n),
    .sync_out (ext_reset_sync_n)
  );

  assign restart_cause = !ext_reset_sync_n | power_on_event
                       | brown_out_event | watchdog_reset_event;

  // Nothing is offered while interrupts are globally off.
  assign live_req = global_irq_enable ? req_vec : '0;

  rvm_prio_enc #(
    .N     (RVM_NUM_SRC),
    .IDX_W (RVM_IDX_W)
  ) u_prio (
    .req   (live_req),
    .found (win_found),
    .idx   (win_idx)
  );

  // ****************************************************************
  // Dispatch state machine.
  // ****************************************************************
  // Current and next dispatch state.
  rvm_state_t                  state_reg;
  rvm_state_t                  state_next;
  // Source being offered or served.
  logic [RVM_IDX_W-1:0]        idx_reg;
  // Decoded events of this cycle.
  wire logic                   take_new;
  wire logic                   accepted;
  wire logic                   withdrawn;
  // Acknowledge pattern for the accepted source.
  wire logic [RVM_NUM_SRC-1:0] ack_pattern;
  // Address of the winner, read from the fixed table.
  wire logic [RVM_PC_W-1:0]    win_addr;

  assign take_new    = (state_reg == RVM_ST_IDLE) && win_found;
  assign accepted    = (state_reg == RVM_ST_OFFER) && cpu_irq_accept;
  // Interrupts switched off before the core accepted: stop offering.
  assign withdrawn   = (state_reg == RVM_ST_OFFER) && !cpu_irq_accept
                     && !global_irq_enable;
  assign ack_pattern = RVM_NUM_SRC'(1) << idx_reg;
  assign win_addr    = RVM_VEC_ADDR[win_idx];

  // Next state; the serve state gives the source one cycle to drop
  // its line before a new choice is made, so it is not taken twice.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RVM_ST_IDLE: begin
        if (take_new) begin
          state_next = RVM_ST_OFFER;
        end
      end
      RVM_ST_OFFER: begin
        if (accepted) begin
          state_next = RVM_ST_SERVE;
        end else if (withdrawn) begin
          state_next = RVM_ST_IDLE;
        end
      end
      RVM_ST_SERVE: begin
        state_next = RVM_ST_IDLE;
      end
      default: begin
        // Code 2'b10 is illegal; recover to idle.
        state_next = RVM_ST_IDLE;
      end
    endcase
  end

  // State register; a reset cause forces the machine back to idle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= RVM_ST_IDLE;
    end else if (restart_cause) begin
      state_reg <= RVM_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // The winner is latched once and held until served.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idx_reg <= '0;
    end else if (take_new && !restart_cause) begin
      idx_reg <= win_idx;
    end
  end

  // ****************************************************************
  // Outputs toward the core and the sources.
  // ****************************************************************
  // Restart request shown one cycle after any reset cause, for as long as it lasts.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fetch_restart <= 1'b1;
    end else begin
      fetch_restart <= restart_cause;
    end
  end

  // Fetch address; the reset entry is fixed at word zero.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vector_addr <= RVM_RESET_ADDR;
    end else if (restart_cause) begin
      vector_addr <= RVM_RESET_ADDR;
    end else if (take_new) begin
      vector_addr <= win_addr;
    end
  end

  // Pending request toward the core, high through the offer state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_pending <= 1'b0;
    end else if (restart_cause || accepted || withdrawn) begin
      irq_pending <= 1'b0;
    end else if (take_new) begin
      irq_pending <= 1'b1;
    end
  end

  // One-cycle acknowledge to the served source, so it clears its flag.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      served_onehot <= '0;
    end else if (accepted && !restart_cause) begin
      served_onehot <= ack_pattern;
    end else begin
      served_onehot <= '0;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_reset_entry;
    restart_cause |=> fetch_restart && vector_addr == 11'h000 && !irq_pending;
  endproperty
  a_reset_entry: assert property (p_reset_entry)
    else $error("reset cause did not fetch word zero");

  property p_ext_pins;
    irq_pending |-> (idx_reg != RVM_SRC_EXT_A || vector_addr == 11'h001)
                 && (idx_reg != RVM_SRC_EXT_B || vector_addr == 11'h002);
  endproperty
  a_ext_pins: assert property (p_ext_pins)
    else $error("external pin vector wrong");

  property p_pin_change;
    irq_pending |-> (idx_reg != RVM_SRC_PCG_A || vector_addr == 11'h003)
                 && (idx_reg != RVM_SRC_PCG_B || vector_addr == 11'h004)
                 && (idx_reg != RVM_SRC_PCG_C || vector_addr == 11'h005);
  endproperty
  a_pin_change: assert property (p_pin_change)
    else $error("pin change vector wrong");

  property p_wdog_t8a;
    irq_pending |-> (idx_reg != RVM_SRC_WDOG || vector_addr == 11'h006)
                 && (idx_reg != RVM_SRC_T8A_MA || vector_addr == 11'h007)
                 && (idx_reg != RVM_SRC_T8A_MB || vector_addr == 11'h008)
                 && (idx_reg != RVM_SRC_T8A_WRAP || vector_addr == 11'h009);
  endproperty
  a_wdog_t8a: assert property (p_wdog_t8a)
    else $error("watchdog or async timer vector wrong");

  property p_t16;
    irq_pending |-> (idx_reg != RVM_SRC_T16_CAP || vector_addr == 11'h00A)
                 && (idx_reg != RVM_SRC_T16_MA || vector_addr == 11'h00B)
                 && (idx_reg != RVM_SRC_T16_MB || vector_addr == 11'h00C)
                 && (idx_reg != RVM_SRC_T16_WRAP || vector_addr == 11'h00D);
  endproperty
  a_t16: assert property (p_t16)
    else $error("16-bit timer vector wrong");

  property p_t8s;
    irq_pending |-> (idx_reg != RVM_SRC_T8S_MA || vector_addr == 11'h00E)
                 && (idx_reg != RVM_SRC_T8S_MB || vector_addr == 11'h00F)
                 && (idx_reg != RVM_SRC_T8S_WRAP || vector_addr == 11'h010);
  endproperty
  a_t8s: assert property (p_t8s)
    else $error("sync timer vector wrong");

  property p_spi;
    irq_pending && idx_reg == RVM_SRC_SPI |-> vector_addr == 11'h011;
  endproperty
  a_spi: assert property (p_spi)
    else $error("serial transfer vector wrong");

  property p_usart;
    irq_pending |-> (idx_reg != RVM_SRC_USART_RX || vector_addr == 11'h012)
                 && (idx_reg != RVM_SRC_USART_BUF || vector_addr == 11'h013)
                 && (idx_reg != RVM_SRC_USART_TX || vector_addr == 11'h014);
  endproperty
  a_usart: assert property (p_usart)
    else $error("usart vector wrong");

  property p_analog_mem;
    irq_pending |-> (idx_reg != RVM_SRC_ADC || vector_addr == 11'h015)
                 && (idx_reg != RVM_SRC_EEPROM || vector_addr == 11'h016)
                 && (idx_reg != RVM_SRC_ACOMP || vector_addr == 11'h017);
  endproperty
  a_analog_mem: assert property (p_analog_mem)
    else $error("adc, eeprom or comparator vector wrong");

  property p_two_wire;
    irq_pending && idx_reg == RVM_SRC_TWO_WIRE |-> vector_addr == 11'h018;
  endproperty
  a_two_wire: assert property (p_two_wire)
    else $error("two-wire vector wrong");

  property p_last_entry;
    irq_pending |-> vector_addr <= 11'h019
                 && (idx_reg != RVM_SRC_SELF_PROG || vector_addr == 11'h019);
  endproperty
  a_last_entry: assert property (p_last_entry)
    else $error("self-program vector wrong or beyond table");

  property p_one_word;
    irq_pending |-> vector_addr == RVM_PC_W'(idx_reg) + 11'h001;
  endproperty
  a_one_word: assert property (p_one_word)
    else $error("vector address is not number less one");

  property p_no_reloc;
    fetch_restart ##1 fetch_restart |-> vector_addr == 11'h000 && !irq_pending;
  endproperty
  a_no_reloc: assert property (p_no_reloc)
    else $error("reset entry moved");

  // The winner's own bit is picked with the index latched at this offer;
  // inside $past the index would be the previous winner's.
  property p_lowest_first;
    $rose(irq_pending) |->
      ($past(live_req) & ~({RVM_NUM_SRC{1'b1}} << idx_reg)) == '0
      && ($past(live_req) & (RVM_NUM_SRC'(1) << idx_reg)) != '0;
  endproperty
  a_lowest_first: assert property (p_lowest_first)
    else $error("a lower vector number was skipped");

  property p_ack_follows;
    irq_pending && cpu_irq_accept && !restart_cause |=>
      served_onehot == ack_pattern && !irq_pending ##1 served_onehot == '0;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("accepted source not acknowledged once");

endmodule : rvm_vector_map

// [shared/rvm_pkg.sv]
package rvm_pkg;

  // ****************************************************************
  // Sizes of the vector map.
  // ****************************************************************
  // Program-memory word address width for the smallest member.
  localparam int RVM_PC_W    = 11;
  // Interrupt sources; the reset entry comes on top of these.
  localparam int RVM_NUM_SRC = 25;
  // Total table entries, reset included.
  localparam int RVM_NUM_VEC = 26;
  // Width of a source index.
  localparam int RVM_IDX_W   = 5;

  // ****************************************************************
  // Source indices, in ascending vector order.
  // ****************************************************************
  localparam logic [4:0] RVM_SRC_EXT_A     = 5'h00;
  localparam logic [4:0] RVM_SRC_EXT_B     = 5'h01;
  localparam logic [4:0] RVM_SRC_PCG_A     = 5'h02;
  localparam logic [4:0] RVM_SRC_PCG_B     = 5'h03;
  localparam logic [4:0] RVM_SRC_PCG_C     = 5'h04;
  localparam logic [4:0] RVM_SRC_WDOG      = 5'h05;
  localparam logic [4:0] RVM_SRC_T8A_MA    = 5'h06;
  localparam logic [4:0] RVM_SRC_T8A_MB    = 5'h07;
  localparam logic [4:0] RVM_SRC_T8A_WRAP  = 5'h08;
  localparam logic [4:0] RVM_SRC_T16_CAP   = 5'h09;
  localparam logic [4:0] RVM_SRC_T16_MA    = 5'h0A;
  localparam logic [4:0] RVM_SRC_T16_MB    = 5'h0B;
  localparam logic [4:0] RVM_SRC_T16_WRAP  = 5'h0C;
  localparam logic [4:0] RVM_SRC_T8S_MA    = 5'h0D;
  localparam logic [4:0] RVM_SRC_T8S_MB    = 5'h0E;
  localparam logic [4:0] RVM_SRC_T8S_WRAP  = 5'h0F;
  localparam logic [4:0] RVM_SRC_SPI       = 5'h10;
  localparam logic [4:0] RVM_SRC_USART_RX  = 5'h11;
  localparam logic [4:0] RVM_SRC_USART_BUF = 5'h12;
  localparam logic [4:0] RVM_SRC_USART_TX  = 5'h13;
  localparam logic [4:0] RVM_SRC_ADC       = 5'h14;
  localparam logic [4:0] RVM_SRC_EEPROM    = 5'h15;
  localparam logic [4:0] RVM_SRC_ACOMP     = 5'h16;
  localparam logic [4:0] RVM_SRC_TWO_WIRE  = 5'h17;
  localparam logic [4:0] RVM_SRC_SELF_PROG = 5'h18;

  // ****************************************************************
  // Word addresses of the table.
  // ****************************************************************
  // All reset causes share this entry; nothing can move it.
  localparam logic [10:0] RVM_RESET_ADDR = 11'h000;
  // Interrupt entries, one word each, indexed by source index.
  localparam logic [10:0] RVM_VEC_ADDR [0:24] = '{
    11'h001, 11'h002, 11'h003, 11'h004, 11'h005,
    11'h006, 11'h007, 11'h008, 11'h009, 11'h00A,
    11'h00B, 11'h00C, 11'h00D, 11'h00E, 11'h00F,
    11'h010, 11'h011, 11'h012, 11'h013, 11'h014,
    11'h015, 11'h016, 11'h017, 11'h018, 11'h019};

  // ****************************************************************
  // Dispatch states, Gray coded along idle, offer, serve.
  // ****************************************************************
  typedef enum logic [1:0] {
    RVM_ST_IDLE  = 2'b00,
    RVM_ST_OFFER = 2'b01,
    RVM_ST_SERVE = 2'b11
  } rvm_state_t;

endpackage : rvm_pkg

// [tb/rvm_core_model.sv]
`timescale 1ns/1ps

// ****************************************************************
// Core-side model: takes offered vectors after a chosen wait.
// ****************************************************************
module rvm_core_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       irq_pending,
  input  wire logic       hold,
  input  wire logic [3:0] wait_cyc,
  input  wire logic       stray,
  output logic            cpu_irq_accept
);
  logic [3:0] cnt_reg;   // Cycles spent looking at the current offer.

  // One-cycle accept pulse once the offer has stood for wait_cyc edges.
  // The cycle after a pulse is skipped, because the offer is still seen
  // high at that edge; a second pulse would reach the map in the serve state and be ignored.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_irq_accept <= 1'b0;
      cnt_reg        <= 4'h0;
    end else begin
      cpu_irq_accept <= 1'b0;
      if (stray && !irq_pending) begin
        // A stray accept is sent only when the bench asks for one.
        cpu_irq_accept <= 1'b1;
      end else if (irq_pending && !cpu_irq_accept && !hold) begin
        if (cnt_reg >= wait_cyc) begin
          cpu_irq_accept <= 1'b1;
          cnt_reg        <= 4'h0;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end else begin
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule : rvm_core_model

// [tb/tb_rvm_vector_map.sv]
`timescale 1ns/1ps

// ****************************************************************
// Bench for the vector map, with a core model on the far side.
// ****************************************************************
`define RVM_CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_rvm_vector_map;
  import rvm_pkg::*;
  logic        clk;             // Core clock, 4 ns period.
  logic        resetn;          // Asynchronous reset, active low.
  logic [3:0]  cause;           // Power-on, brown-out, watchdog, pin.
  logic        irq_en;          // Global interrupt enable.
  logic [24:0] req;             // Peripheral request levels by index.
  logic        hold;            // Core model refuses to accept.
  logic [3:0]  wait_cyc;        // Core model accept latency.
  logic        stray;           // Core model sends an unasked accept.
  logic        cpu_irq_accept;  // Accept pulse from the core model.
  logic        fetch_restart;
  logic        irq_pending;
  logic [10:0] vector_addr;
  logic [24:0] served_onehot;
  int          mismatches;
  int          compares;

  rvm_vector_map uut (
    .clk(clk), .resetn(resetn), .ext_reset_pin_n(~cause[3]),
    .power_on_event(cause[0]), .brown_out_event(cause[1]),
    .watchdog_reset_event(cause[2]), .global_irq_enable(irq_en),
    .cpu_irq_accept(cpu_irq_accept), .ext_pin_irq_a(req[0]), .ext_pin_irq_b(req[1]),
    .pin_change_group_a(req[2]), .pin_change_group_b(req[3]),
    .pin_change_group_c(req[4]), .watchdog_timeout_irq(req[5]),
    .t8b_async_match_a(req[6]), .t8b_async_match_b(req[7]), .t8b_async_wrap(req[8]),
    .t16_capture_irq(req[9]), .t16_match_a(req[10]), .t16_match_b(req[11]),
    .t16_wrap(req[12]), .t8b_sync_match_a(req[13]), .t8b_sync_match_b(req[14]),
    .t8b_sync_wrap(req[15]), .spi_xfer_done_irq(req[16]), .usart_rx_done_irq(req[17]),
    .usart_tx_buf_empty_irq(req[18]), .usart_tx_done_irq(req[19]),
    .adc_done_irq(req[20]), .eeprom_idle_irq(req[21]), .acomp_irq(req[22]),
    .two_wire_irq(req[23]), .self_program_idle_irq(req[24]),
    .fetch_restart(fetch_restart), .irq_pending(irq_pending),
    .vector_addr(vector_addr), .served_onehot(served_onehot)
  );

  rvm_core_model core (
    .clk(clk), .resetn(resetn), .irq_pending(irq_pending), .hold(hold),
    .wait_cyc(wait_cyc), .stray(stray), .cpu_irq_accept(cpu_irq_accept)
  );

  // ****************************************************************
  // Shared steps.
  // ****************************************************************
  // Waits, with a bound, until an offer stands at a settled point.
  task automatic wait_offer;
    int k;
    k = 0;
    while (irq_pending !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    `RVM_CHK(irq_pending, 1'b1)
  endtask : wait_offer

  // The peripheral clears its flag at the edge that takes the accept,
  // as a real flag cleared on acknowledge would; then the pulse is checked.
  task automatic take(input int i);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (cpu_irq_accept !== 1'b1 && k < 20);
    req[i] <= 1'b0;
    @(negedge clk);
    `RVM_CHK(served_onehot, 25'h0000001 << i)
  endtask : take

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  // Every source alone, with the core answering promptly and slowly.
  task automatic t_table;
    for (int i = 0; i < 25; i++) begin
      @(posedge clk);
      wait_cyc <= 4'(i % 4);
      req[i]   <= 1'b1;
      wait_offer();
      `RVM_CHK(vector_addr, 11'(i+1))
      take(i);
    end
    $display("test table done");
  endtask : t_table

  // All 25 requests at once must be served in ascending order.
  task automatic t_prio;
    @(posedge clk);
    wait_cyc <= 4'h0;
    req      <= 25'h1FFFFFF;
    for (int i = 0; i < 25; i++) begin
      wait_offer();
      `RVM_CHK(vector_addr, 11'(i + 1))
      take(i);
    end
    $display("test priority done");
  endtask : t_prio

  // Each reset cause pulls fetch to word zero over a standing offer.
  task automatic t_reset;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      hold    <= 1'b1;
      req[24] <= 1'b1;
      wait_offer();
      `RVM_CHK(vector_addr, 11'h019)
      @(posedge clk);
      cause[c] <= 1'b1;
      repeat (c == 3 ? 3 : 1) @(posedge clk);
      @(negedge clk);
      `RVM_CHK({fetch_restart, irq_pending, vector_addr}, 13'h1000)
      @(posedge clk);
      cause[c] <= 1'b0;
      hold     <= 1'b0;
      repeat (c == 3 ? 3 : 1) @(posedge clk);
      @(negedge clk);
      `RVM_CHK(fetch_restart, 1'b0)
      wait_offer();
      `RVM_CHK(vector_addr, 11'h019)
      take(24);
    end
    $display("test reset causes done");
  endtask : t_reset

  // Stray accept, enable drop during an offer, reset in mid-run.
  task automatic t_refuse;
    @(posedge clk);
    stray <= 1'b1;
    @(posedge clk);
    stray <= 1'b0;
    repeat (3) begin
      @(negedge clk);
      `RVM_CHK(served_onehot, 25'h0000000)
    end
    @(posedge clk);
    hold   <= 1'b1;
    req[9] <= 1'b1;
    wait_offer();
    `RVM_CHK(vector_addr, 11'h00A)
    @(posedge clk);
    irq_en <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    `RVM_CHK({irq_pending, served_onehot}, 26'h0000000)
    @(posedge clk);
    irq_en <= 1'b1;
    hold   <= 1'b0;
    wait_offer();
    `RVM_CHK(vector_addr, 11'h00A)
    take(9);
    @(posedge clk);
    resetn <= 1'b0;
    @(negedge clk);
    `RVM_CHK({fetch_restart, irq_pending, vector_addr, served_onehot}, 38'h2000000000)
    @(posedge clk);
    resetn <= 1'b1;
    req[3] <= 1'b1;
    // The release edge itself still resets; the next edge offers at once.
    @(negedge clk);
    `RVM_CHK(fetch_restart, 1'b1)
    @(negedge clk);
    `RVM_CHK({fetch_restart, irq_pending, vector_addr}, 13'h0804)
    take(3);
    $display("test refusals done");
  endtask : t_refuse

  // ****************************************************************
  // Clock, verdict, watchdog and main sequence.
  // ****************************************************************
  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // The tests need well under 2000 cycles; this cuts a hang short.
  initial begin
    #40000;
    mismatches++;
    end_of_test();
  end

  // Reset for four cycles, then the scenarios in turn.
  initial begin
    mismatches = 0;
    compares   = 0;
    resetn     = 1'b0;
    cause      = 4'h0;
    irq_en     = 1'b1;
    req        = 25'h0000000;
    hold       = 1'b0;
    wait_cyc   = 4'h0;
    stray      = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_table();
    t_prio();
    t_reset();
    t_refuse();
    end_of_test();
  end
endmodule : tb_rvm_vector_map
